// *** src/spb_defines.svh ***
`ifndef SPB_DEFINES_SVH
`define SPB_DEFINES_SVH

// register indices; each sits at four times its index on the bus
`define SPB_ADDR_PIN_FUNCTION_SELECT 8'hA6
`define SPB_ADDR_TOUCH 8'hA7
`define SPB_ADDR_IEMAIN 8'hA8
`define SPB_ADDR_IEEXTRA 8'hA9
`define SPB_ADDR_ADCLOW 8'hAA
`define SPB_ADDR_ADCHIGH 8'hAB

// reset values
`define SPB_RST_PIN_FUNCTION_SELECT 8'h00
`define SPB_RST_TOUCH 5'h1F
`define SPB_RST_IEMAIN 8'h00
`define SPB_RST_IEEXTRA 8'h00

// pin function field positions
`define SPB_BIT_I2C_SWAP 6
`define SPB_BIT_CLKHALF_EN 5
`define SPB_BIT_T2TOG_EN 4
`define SPB_BIT_SINK2_EN 3
`define SPB_BIT_SINK1_EN 2
`define SPB_BIT_SINK0_EN 1
`define SPB_BIT_T0DIV_EN 0

// main interrupt enable fields
`define SPB_BIT_GLOBAL 7
`define SPB_BIT_TIMER2 5
`define SPB_BIT_UART1 4
`define SPB_BIT_TIMER1 3
`define SPB_BIT_EXT1 2
`define SPB_BIT_TIMER0 1
`define SPB_BIT_EXT0 0

// extra interrupt enable fields
`define SPB_BIT_PWM 7
`define SPB_BIT_I2C 6
`define SPB_BIT_UART2 5
`define SPB_BIT_SPI 4
`define SPB_BIT_ADTK 3
`define SPB_BIT_EXTLV 2
`define SPB_BIT_PORT1 1
`define SPB_BIT_TIMER3 0

// timer0 overflow divider
`define SPB_T0_DIV 64
`define SPB_T0_DIV_W 5

// touch channel codes
`define SPB_TK_LAST_CH 5'h13
`define SPB_TK_REFCAP 5'h17

`endif

// *** src/spb_pkg.sv ***
package spb_pkg;
	typedef logic [7:0] spb_byte_t;
	typedef logic [11:0] spb_adc_t;
	typedef logic [4:0] spb_tkch_t;
	typedef enum logic [1:0] {
		SPB_HTRANS_IDLE = 2'h0,
		SPB_HTRANS_BUSY = 2'h1,
		SPB_HTRANS_NONSEQ = 2'h2,
		SPB_HTRANS_SEQ = 2'h3
	} spb_htrans_t;
endpackage

// *** src/spb_pin_outputs.sv ***
`timescale 1ns/1ps
`include "spb_defines.svh"
module spb_pin_outputs
	import spb_pkg::*;
#(
	parameter int T0_DIV = `SPB_T0_DIV
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clkhalf_en,
	input wire logic t2tog_en,
	input wire logic t0div_en,
	input wire logic timer2_ovf,
	input wire logic timer0_ovf,
	output logic sysclk_half_out,
	output logic timer2_toggle_out,
	output logic timer0_div64_out
);
	localparam int HALF = T0_DIV / 2;
	localparam int CW = $clog2(HALF);
	logic half_reg;
	logic t2_reg;
	logic t0_reg;
	logic [CW-1:0] t0cnt_reg;

	// system clock halved, held low when disabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			half_reg <= 1'b0;
		else if (clkhalf_en)
			half_reg <= ~half_reg;
		else
			half_reg <= 1'b0;
	end

	// toggles once per timer2 overflow
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			t2_reg <= 1'b0;
		else if (!t2tog_en)
			t2_reg <= 1'b0;
		else if (timer2_ovf)
			t2_reg <= ~t2_reg;
	end

	// toggles every T0_DIV/2 overflows, half a period of T0_DIV (64 by default)
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			t0cnt_reg <= '0;
			t0_reg <= 1'b0;
		end else if (!t0div_en) begin
			t0cnt_reg <= '0;
			t0_reg <= 1'b0;
		end else if (timer0_ovf) begin
			if (t0cnt_reg == CW'(HALF - 1)) begin
				t0cnt_reg <= '0;
				t0_reg <= ~t0_reg;
			end else begin
				t0cnt_reg <= t0cnt_reg + 1'b1;
			end
		end
	end

	assign sysclk_half_out = half_reg;
	assign timer2_toggle_out = t2_reg;
	assign timer0_div64_out = t0_reg;
endmodule

// *** src/spb_irq_gate.sv ***
`timescale 1ns/1ps
`include "spb_defines.svh"
module spb_irq_gate
	import spb_pkg::*;
(
	input wire logic [7:0] ie_main,
	input wire logic [7:0] ie_extra,
	input wire logic [15:0] irq_src,
	output logic [15:0] irq_req,
	output logic ext_pin0_wake_en,
	output logic ext_pin1_wake_en,
	output logic ext_pins_wake_en
);
	logic [15:0] en_vec;

	// source order: main bits 6..0 map to 6..0 minus unused bit 6, extra to 15..8
	assign en_vec = {ie_extra, 1'b0, ie_main[6:0] & 7'h3F};

	// global gate ahead of each source enable
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_gate
			assign irq_req[i] = ie_main[`SPB_BIT_GLOBAL] & en_vec[i] & irq_src[i];
		end
	endgenerate

	// wake-up follows the pin enables alone
	assign ext_pin0_wake_en = ie_main[`SPB_BIT_EXT0];
	assign ext_pin1_wake_en = ie_main[`SPB_BIT_EXT1];
	assign ext_pins_wake_en = ie_extra[`SPB_BIT_EXTLV];
endmodule

// *** src/spb_sfr_bank.sv ***
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "spb_defines.svh"
module spb_sfr_bank
	import spb_pkg::*;
#(
	parameter int T0_DIV = `SPB_T0_DIV
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [11:0] adc_result,
	input wire logic timer2_ovf,
	input wire logic timer0_ovf,
	input wire logic [15:0] irq_src,
	output logic [15:0] irq_req,
	output logic ext_pin0_wake_en,
	output logic ext_pin1_wake_en,
	output logic ext_pins_wake_en,
	output logic i2c_pin_swap,
	output logic i2c_on_p34_p35,
	output logic i2c_on_p30_p31,
	output logic sysclk_half_out_en,
	output logic sysclk_half_out,
	output logic timer2_toggle_out_en,
	output logic timer2_toggle_out,
	output logic timer0_div64_out_en,
	output logic timer0_div64_out,
	output logic high_sink_group2_en,
	output logic high_sink_group1_en,
	output logic high_sink_group0_en,
	output logic [4:0] first_touch_channel,
	output logic touch_refcap_sel,
	output logic touch_code_valid
);
	spb_byte_t pin_function_select_reg;
	spb_tkch_t touch_reg;
	spb_byte_t iemain_reg;
	spb_byte_t ieextra_reg;
	logic [7:0] wr_addr_reg;
	logic wr_pend_reg;
	logic [31:0] hrdata_reg;
	spb_byte_t rd_byte;
	logic addr_ok;
	logic take;

	// address phase taken on any NONSEQ or SEQ transfer; hsize is not checked
	assign take = hsel && hready && htrans[1];
	assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);

	// zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// latch address phase for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= take && hwrite && addr_ok;
			if (take)
				wr_addr_reg <= haddr[9:2];
		end
	end

	// pin function register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pin_function_select_reg <= `SPB_RST_PIN_FUNCTION_SELECT;
		else if (wr_pend_reg && wr_addr_reg == `SPB_ADDR_PIN_FUNCTION_SELECT)
			pin_function_select_reg <= {1'b0, hwdata[6:0]};
	end

	// first touch channel register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			touch_reg <= `SPB_RST_TOUCH;
		else if (wr_pend_reg && wr_addr_reg == `SPB_ADDR_TOUCH)
			touch_reg <= hwdata[4:0];
	end

	// interrupt enable registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			iemain_reg <= `SPB_RST_IEMAIN;
			ieextra_reg <= `SPB_RST_IEEXTRA;
		end else begin
			if (wr_pend_reg && wr_addr_reg == `SPB_ADDR_IEMAIN)
				iemain_reg <= {hwdata[7], 1'b0, hwdata[5:0]};
			if (wr_pend_reg && wr_addr_reg == `SPB_ADDR_IEEXTRA)
				ieextra_reg <= hwdata[7:0];
		end
	end

	// read mux; result registers have no write path
	always_comb begin
		rd_byte = 8'h00;
		unique case (haddr[9:2])
			`SPB_ADDR_PIN_FUNCTION_SELECT: rd_byte = pin_function_select_reg;
			`SPB_ADDR_TOUCH: rd_byte = {3'h0, touch_reg};
			`SPB_ADDR_IEMAIN: rd_byte = iemain_reg;
			`SPB_ADDR_IEEXTRA: rd_byte = ieextra_reg;
			`SPB_ADDR_ADCLOW: rd_byte = {adc_result[3:0], 4'h0};
			`SPB_ADDR_ADCHIGH: rd_byte = adc_result[11:4];
			default: rd_byte = 8'h00;
		endcase
	end

	// read data captured at the address phase, zero outside a read data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_reg <= 32'h00000000;
		else if (take && !hwrite && addr_ok)
			hrdata_reg <= {24'h000000, rd_byte};
		else
			hrdata_reg <= 32'h00000000;
	end
	assign hrdata = hrdata_reg;

	// pin routing controls
	assign i2c_pin_swap = pin_function_select_reg[`SPB_BIT_I2C_SWAP];
	assign i2c_on_p34_p35 = ~pin_function_select_reg[`SPB_BIT_I2C_SWAP];
	assign i2c_on_p30_p31 = pin_function_select_reg[`SPB_BIT_I2C_SWAP];
	assign sysclk_half_out_en = pin_function_select_reg[`SPB_BIT_CLKHALF_EN];
	assign timer2_toggle_out_en = pin_function_select_reg[`SPB_BIT_T2TOG_EN];
	assign timer0_div64_out_en = pin_function_select_reg[`SPB_BIT_T0DIV_EN];
	assign high_sink_group2_en = pin_function_select_reg[`SPB_BIT_SINK2_EN];
	assign high_sink_group1_en = pin_function_select_reg[`SPB_BIT_SINK1_EN];
	assign high_sink_group0_en = pin_function_select_reg[`SPB_BIT_SINK0_EN];

	// touch channel decode
	assign first_touch_channel = touch_reg;
	assign touch_refcap_sel = (touch_reg == `SPB_TK_REFCAP);
	assign touch_code_valid = (touch_reg <= `SPB_TK_LAST_CH) || touch_refcap_sel;

	// divided clock and overflow outputs
	spb_pin_outputs #(
		.T0_DIV(T0_DIV)
	) u_pins (
		.hclk(hclk),
		.hresetn(hresetn),
		.clkhalf_en(pin_function_select_reg[`SPB_BIT_CLKHALF_EN]),
		.t2tog_en(pin_function_select_reg[`SPB_BIT_T2TOG_EN]),
		.t0div_en(pin_function_select_reg[`SPB_BIT_T0DIV_EN]),
		.timer2_ovf(timer2_ovf),
		.timer0_ovf(timer0_ovf),
		.sysclk_half_out(sysclk_half_out),
		.timer2_toggle_out(timer2_toggle_out),
		.timer0_div64_out(timer0_div64_out)
	);

	// interrupt gating; adc/touch source at index 11
	spb_irq_gate u_irq (
		.ie_main(iemain_reg),
		.ie_extra(ieextra_reg),
		.irq_src(irq_src),
		.irq_req(irq_req),
		.ext_pin0_wake_en(ext_pin0_wake_en),
		.ext_pin1_wake_en(ext_pin1_wake_en),
		.ext_pins_wake_en(ext_pins_wake_en)
	);
endmodule

// *** testbench/spb_sfr_bank_asserts.sv ***
`timescale 1ns/1ps
module spb_sfr_bank_asserts #(
	parameter int T0_DIV = 64
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic timer2_ovf,
	input wire logic [15:0] irq_src,
	input wire logic [15:0] irq_req,
	input wire logic ext_pin0_wake_en,
	input wire logic i2c_pin_swap,
	input wire logic i2c_on_p34_p35,
	input wire logic sysclk_half_out_en,
	input wire logic sysclk_half_out,
	input wire logic timer2_toggle_out_en,
	input wire logic timer2_toggle_out,
	input wire logic [4:0] first_touch_channel,
	input wire logic touch_refcap_sel,
	input wire logic touch_code_valid
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// bus answer, pin routing, divided output, gating and touch decode relations
	a_bus_always_ready: assert property (hreadyout && !hresp) else $error("bus not ready/okay");
	a_i2c_pin_route: assert property (i2c_on_p34_p35 == !i2c_pin_swap) else $error("i2c route");
	a_half_clk_toggle: assert property ($past(sysclk_half_out_en) && sysclk_half_out_en
		|-> sysclk_half_out != $past(sysclk_half_out)) else $error("half clock stuck");
	a_half_clk_off: assert property (!sysclk_half_out_en ##1 !sysclk_half_out_en
		|-> !sysclk_half_out) else $error("half clock while off");
	a_t2_out_flip: assert property (timer2_ovf && timer2_toggle_out_en && $past(timer2_toggle_out_en)
		|=> timer2_toggle_out != $past(timer2_toggle_out)) else $error("t2 no toggle");
	a_irq_src_gate: assert property ((irq_req & ~irq_src) == 16'h0000 && irq_req[7:6] == 2'h0)
		else $error("irq without source");
	a_ext0_wake_tie: assert property (irq_req[0] |-> ext_pin0_wake_en) else $error("wake");
	a_refcap_code: assert property (touch_refcap_sel == (first_touch_channel == 5'h17))
		else $error("refcap decode");
	a_touch_code_ok: assert property (touch_code_valid == (first_touch_channel <= 5'h13
		|| first_touch_channel == 5'h17)) else $error("touch code decode");
	// main scenarios reached
	c_half_clk: cover property (sysclk_half_out_en ##1 sysclk_half_out_en);
	c_t2_pulse: cover property (timer2_ovf && timer2_toggle_out_en);
	c_irq_out: cover property (irq_req != 16'h0000);
endmodule
bind spb_sfr_bank spb_sfr_bank_asserts #(.T0_DIV(T0_DIV)) u_chk (.hclk, .hresetn, .hreadyout,
	.hresp, .timer2_ovf, .irq_src, .irq_req, .ext_pin0_wake_en, .i2c_pin_swap, .i2c_on_p34_p35,
	.sysclk_half_out_en, .sysclk_half_out, .timer2_toggle_out_en, .timer2_toggle_out,
	.first_touch_channel, .touch_refcap_sel, .touch_code_valid);

// *** testbench/spb_sfr_bank_tb.sv ***
`timescale 1ns/1ps
`include "spb_defines.svh"
module spb_sfr_bank_tb;
	import spb_pkg::*;
	typedef struct {spb_byte_t idx; spb_byte_t wd; spb_byte_t exp; spb_byte_t rst;} spb_row_t;
	logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hready, hreadyout, hresp, b;
	logic timer2_ovf = 0, timer0_ovf = 0, ext_pin0_wake_en, ext_pin1_wake_en, ext_pins_wake_en;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [11:0] adc_result = 12'h5A3;
	logic [15:0] irq_src = 16'hFFFF, irq_req;
	logic i2c_pin_swap, i2c_on_p34_p35, i2c_on_p30_p31, sysclk_half_out_en, sysclk_half_out;
	logic timer2_toggle_out_en, timer2_toggle_out, timer0_div64_out_en, timer0_div64_out;
	logic high_sink_group2_en, high_sink_group1_en, high_sink_group0_en;
	logic touch_refcap_sel, touch_code_valid;
	logic [4:0] first_touch_channel;
	spb_byte_t rd;
	int n_mismatch = 0, total_checks = 0;
	// register index, write value, readback, value after reset
	spb_row_t rows[8] = '{
		'{`SPB_ADDR_PIN_FUNCTION_SELECT, 8'hFF, 8'h7F, 8'h00},
		'{`SPB_ADDR_TOUCH, 8'hF4, 8'h14, 8'h1F},
		'{`SPB_ADDR_TOUCH, 8'h17, 8'h17, 8'h1F},
		'{`SPB_ADDR_IEMAIN, 8'hFF, 8'hBF, 8'h00},
		'{`SPB_ADDR_IEEXTRA, 8'hFF, 8'hFF, 8'h00},
		'{`SPB_ADDR_ADCLOW, 8'hFF, 8'h30, 8'h30},
		'{`SPB_ADDR_ADCHIGH, 8'h00, 8'h5A, 8'h5A},
		'{8'hAC, 8'hFF, 8'h00, 8'h00}};
	assign hready = hreadyout;
	always #20 hclk = ~hclk;
	spb_sfr_bank #(.T0_DIV(4)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .adc_result, .timer2_ovf, .timer0_ovf,
		.irq_src, .irq_req, .ext_pin0_wake_en, .ext_pin1_wake_en, .ext_pins_wake_en,
		.i2c_pin_swap, .i2c_on_p34_p35, .i2c_on_p30_p31, .sysclk_half_out_en, .sysclk_half_out,
		.timer2_toggle_out_en, .timer2_toggle_out, .timer0_div64_out_en, .timer0_div64_out,
		.high_sink_group2_en, .high_sink_group1_en, .high_sink_group0_en, .first_touch_channel,
		.touch_refcap_sel, .touch_code_valid);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one single word transfer; registers sit at four times their index
	task xfer(input logic w, input spb_byte_t idx, input spb_byte_t wd);
		@(posedge hclk);
		htrans <= SPB_HTRANS_NONSEQ;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= SPB_HTRANS_IDLE;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge hclk);
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1;
		// write then read back every row
		foreach (rows[i]) begin
			xfer(1, rows[i].idx, rows[i].wd);
			xfer(0, rows[i].idx, 8'h00);
			chk(rd, rows[i].exp);
		end
		@(posedge hclk);
		chk({i2c_pin_swap, i2c_on_p30_p31, high_sink_group2_en, high_sink_group1_en,
			high_sink_group0_en}, 5'h1F);
		chk({touch_refcap_sel, touch_code_valid, first_touch_channel}, 7'h77);
		chk({irq_req, ext_pin0_wake_en, ext_pin1_wake_en, ext_pins_wake_en},
			{16'hFF3F, 3'h7});
		b = sysclk_half_out;
		@(posedge hclk);
		chk(sysclk_half_out, !b);
		// timer outputs flip per overflow, per two overflows at the short divider
		b = timer2_toggle_out;
		timer2_ovf <= 1;
		@(posedge hclk);
		timer2_ovf <= 0;
		@(posedge hclk);
		chk(timer2_toggle_out, !b);
		b = timer0_div64_out;
		repeat (2) begin
			timer0_ovf <= 1;
			@(posedge hclk);
			timer0_ovf <= 0;
			@(posedge hclk);
		end
		chk(timer0_div64_out, !b);
		xfer(1, `SPB_ADDR_IEMAIN, 8'h7F);
		@(posedge hclk);
		chk(irq_req, 16'h0000);
		// reset in mid-run brings back reset values
		hresetn <= 0;
		@(posedge hclk);
		hresetn <= 1;
		foreach (rows[i]) begin
			xfer(0, rows[i].idx, 8'h00);
			chk(rd, rows[i].rst);
		end
		close_out();
	end
endmodule
